// *** picd_top.sv ***
// Pin input change detect: register file and interrupt
// Assumes a simple synchronous host port, one access per strobe
`timescale 1ns/1ps
`include "picd_consts.svh"
module picd_top
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins
    input wire logic [7:0] gp_pins,
    input wire logic network_reference_pin_one,
    input wire logic network_reference_pin_two,
    // Host port
    input wire logic [`PICD_ADDR_W-1:0] host_addr,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire picd_pkg::picd_word_t host_wdata,
    output picd_pkg::picd_word_t host_rdata,
    // Interrupt
    output logic pin_change_irq
);
    picd_pkg::picd_pins_t pins;
    picd_pkg::picd_pins_t level;
    picd_pkg::picd_pins_t changed;
    picd_pkg::picd_pins_t flags_reg;
    picd_pkg::picd_pins_t flags_next;
    picd_pkg::picd_pins_t irq_en_reg;
    picd_pkg::picd_word_t rdata_next;

    function automatic picd_pkg::picd_word_t widen(picd_pkg::picd_pins_t v);
        widen = {6'h00, v};
    endfunction

    assign pins = {network_reference_pin_two, network_reference_pin_one,
                   gp_pins};

    picd_sampler u_sampler
    (
        .clk(clk),
        .rst_n(rst_n),
        .pins(pins),
        .level(level),
        .changed(changed)
    );

    // ****************************************
    // Change flags
    // ****************************************
    // A change in the read cycle survives the clear
    always_comb
    begin
        flags_next = flags_reg;
        if (host_rd && host_addr == `PICD_OFF_FLAGS)
            flags_next = '0;
        flags_next = flags_next | changed;
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            flags_reg <= `PICD_RST_FLAGS;
        else
            flags_reg <= flags_next;
    end

    // ****************************************
    // Enables
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            irq_en_reg <= `PICD_RST_IRQ_EN;
        else if (host_wr && host_addr == `PICD_OFF_IRQ_EN)
            irq_en_reg <= host_wdata[`PICD_PIN_N-1:0];
    end

    // ****************************************
    // Read data and interrupt
    // ****************************************
    always_comb
    begin
        rdata_next = host_rdata;
        if (host_rd)
        begin
            unique case (host_addr)
                `PICD_OFF_LEVELS: rdata_next = widen(level);
                `PICD_OFF_FLAGS: rdata_next = widen(flags_reg);
                `PICD_OFF_IRQ_EN: rdata_next = widen(irq_en_reg);
                default: rdata_next = 16'h0000;
            endcase
        end
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            host_rdata <= 16'h0000;
        else
            host_rdata <= rdata_next;
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pin_change_irq <= 1'b0;
        else
            pin_change_irq <= |(flags_next & irq_en_reg);
    end
endmodule // picd_top

// *** picd_consts.svh ***
// Constants for the pin input change detect block
// Assumes inclusion by bare name from design files
`ifndef PICD_CONSTS_SVH
`define PICD_CONSTS_SVH
`define PICD_ADDR_W 12
`define PICD_DATA_W 16
`define PICD_PIN_N 10
`define PICD_OFF_LEVELS 12'h074A
`define PICD_OFF_FLAGS 12'h074C
`define PICD_OFF_IRQ_EN 12'h074E
`define PICD_RST_FLAGS 10'h000
`define PICD_RST_IRQ_EN 10'h000
`define PICD_NETREF_ONE_BIT 8
`define PICD_NETREF_TWO_BIT 9
`endif

// *** picd_pkg.sv ***
// Types for the pin input change detect block
// Assumes picd_consts.svh is on the include path
`include "picd_consts.svh"
package picd_pkg;
    typedef logic [`PICD_PIN_N-1:0] picd_pins_t;
    typedef logic [`PICD_DATA_W-1:0] picd_word_t;
endpackage

// *** picd_sampler.sv ***
// Pin sampler and change detector
// Assumes pins are synchronous to clk
`timescale 1ns/1ps
`include "picd_consts.svh"
module picd_sampler
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins
    input wire picd_pkg::picd_pins_t pins,
    // Results
    output picd_pkg::picd_pins_t level,
    output picd_pkg::picd_pins_t changed
);
    // ****************************************
    // Sampling
    // ****************************************
    // Reset clears level; primed_reg masks changed until level holds the pins, so reset release flags nothing
    logic primed_reg;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            level <= '0;
        else
            level <= pins;
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            primed_reg <= 1'b0;
        else
            primed_reg <= 1'b1;
    end
    assign changed = primed_reg ? (pins ^ level) : '0;
endmodule // picd_sampler

// *** picd_top_sva.sv ***
// Checker on the ports of picd_top
// Assumes a bind onto picd_top
`timescale 1ns/1ps
module picd_chk(input wire logic clk,rst_n,host_rd,host_wr,pin_change_irq,
input wire logic network_reference_pin_one,network_reference_pin_two,
input wire logic [7:0] gp_pins,input wire logic [11:0] host_addr,
input wire picd_pkg::picd_word_t host_wdata,host_rdata);
wire [9:0] p={network_reference_pin_two,network_reference_pin_one,gp_pins};
wire [5:0] hi=p[9:4];
wire rf=host_rd&&host_addr==12'h74c;
wire we=host_wr&&host_addr==12'h74e;
logic [9:0] en_reg;
// Shadow of the enables
always_ff @(posedge clk)
    en_reg<=!rst_n?10'h000:we?host_wdata[9:0]:en_reg;
default clocking @(posedge clk); endclocking
default disable iff(!rst_n);
property p_lvl; host_rd&&host_addr==12'h74a|=>host_rdata[9:4]==$past(hi,2);
endproperty
a_lvl: assert property(p_lvl) else $error("level");
property p_hi; host_rdata[15:10]==6'h00; endproperty
a_hi: assert property(p_hi) else $error("upper");
property p_set; $past(rst_n)&&|((p^$past(p))&en_reg)|=>pin_change_irq;
endproperty
a_set: assert property(p_set) else $error("set");
property p_off; (en_reg==10'h000)[*2]|->!pin_change_irq; endproperty
a_off: assert property(p_off) else $error("mask");
property p_rst; $rose(rst_n)|->!pin_change_irq&&host_rdata==16'h0000;
endproperty
a_rst: assert property(p_rst) else $error("reset");
property p_clr; rf&&$stable(p)|=>!pin_change_irq; endproperty
a_clr: assert property(p_clr) else $error("clear");
property p_hold; pin_change_irq&&!rf&&!we|=>pin_change_irq; endproperty
a_hold: assert property(p_hold) else $error("hold");
cover property($rose(pin_change_irq));
cover property(rf##1!pin_change_irq);
cover property(we##1en_reg==10'h000);
endmodule // picd_chk
bind picd_top picd_chk u_chk(.*);

// *** picd_board.sv ***
// Board-side pin driver
// Assumes pins move only just after clk rises
`timescale 1ns/1ps
module picd_board(input wire logic clk,go,input wire logic [9:0] m,
output logic [9:0] pins);
initial pins=10'h000;
always @(posedge clk)
    pins<=#1 go?10'($urandom):m;
endmodule // picd_board

// *** tb_top.sv ***
// Testbench for picd_top
// Assumes picd_board drives the pins
`timescale 1ns/1ps
module tb_top;
logic clk=0,rst_n=0,rd=0,wr=0,go=0,irq;
logic [9:0] m=0,p,nv,ev,ov;
logic [11:0] a=0;
picd_pkg::picd_word_t wd=0,rdt;
int fail_count=0,total_checks=0,i;
picd_top uut(.clk,.rst_n,.gp_pins(p[7:0]),.network_reference_pin_one(p[8]),
.network_reference_pin_two(p[9]),.host_addr(a),.host_rd(rd),.host_wr(wr),
.host_wdata(wd),.host_rdata(rdt),.pin_change_irq(irq));
picd_board brd(.clk,.go,.m,.pins(p));
initial forever #50 clk=~clk;
function picd_pkg::picd_word_t ex(input logic [9:0] v);
    return {6'h00,v};
endfunction
task chk(input picd_pkg::picd_word_t g,e);
    total_checks++;
    if(g!==e)
    begin
        fail_count++;
        $display("BAD %0t got %h exp %h",$time,g,e);
    end
endtask
task acc(input logic w,input logic [11:0] ad,input picd_pkg::picd_word_t d);
    @(posedge clk);
    #1 {a,wd,rd,wr}={ad,d,!w,w};
    @(posedge clk);
    #1 {rd,wr}=2'b00;
endtask
task rdc(input logic [11:0] ad,input picd_pkg::picd_word_t e);
    acc(0,ad,0);
    chk(rdt,e);
endtask
task summarize;
    $display("checks %0d fails %0d",total_checks,fail_count);
    if(fail_count==0&&total_checks>0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask
initial
begin
    #2000000 fail_count++;
    summarize;
end
initial
begin
    void'($urandom(32'hb4d0));
    repeat(20) @(posedge clk);
    #1 rst_n=1;
    rdc(12'h74c,0);
    rdc(12'h74e,0);
    acc(1,12'h74e,16'hffff);
    rdc(12'h74e,16'h03ff);
    acc(1,12'h74a,16'hffff);
    rdc(12'h7f0,0);
    for(i=0;i<10;i++)
    begin
        m^=10'(1<<i);
        repeat(3) @(posedge clk);
        #1 chk(irq,1);
        rdc(12'h74a,ex(m));
        rdc(12'h74c,ex(10'(1<<i)));
        chk(irq,0);
    end
    acc(1,12'h74e,0);
    m=0;
    repeat(3) @(posedge clk);
    #1 chk(irq,0);
    rdc(12'h74c,16'h03ff);
    // Random pin patterns against random enables
    for(i=0;i<40;i++)
    begin
        nv=10'($urandom);
        ev=10'($urandom);
        acc(1,12'h74e,ex(ev));
        ov=m;
        m=nv;
        repeat(3) @(posedge clk);
        #1 chk(irq,|((ov^nv)&ev));
        rdc(12'h74a,ex(nv));
        rdc(12'h74c,ex(ov^nv));
        chk(irq,0);
    end
    go=1;
    repeat(300) acc($urandom%2,12'h74a+12'($urandom%3)*2,$urandom);
    go=0;
    repeat(3) @(posedge clk);
    acc(0,12'h74c,0);
    rdc(12'h74c,0);
    chk(irq,0);
    rdc(12'h74a,ex(m));
    summarize;
end
endmodule // tb_top
